// file: qtd_consts.vh
// Constants for the queue transfer descriptor engine.
`ifndef QTD_CONSTS_VH
`define QTD_CONSTS_VH

// Software register offsets, byte addresses on the register port.
`define QTD_REG_CTRL 8'h00
`define QTD_REG_HEAD 8'h04
`define QTD_REG_STAT 8'h08
`define QTD_REG_WORD2 8'h0C
`define QTD_REG_CUR 8'h10
`define QTD_REG_ADDR_W 8

// Control register bits.
`define QTD_CTRL_START 0
`define QTD_CTRL_ABORT 1

// Descriptor geometry: eight words in one 32-byte line.
`define QTD_WORDS 4'h8
`define QTD_LINE_MASK 32'hFFFFFFE0
`define QTD_WORD_TOGGLE 3'h2
`define QTD_WORD_PAGE0 3'h3

// Link word layout.
`define QTD_LINK_TERM 0

// Word two layout.
`define QTD_TOGGLE_BIT 31
`define QTD_TOTAL_HI 30
`define QTD_TOTAL_LO 16
`define QTD_NOTIFY_BIT 15
`define QTD_PAGE_HI 14
`define QTD_PAGE_LO 12
`define QTD_ERRCNT_HI 11
`define QTD_ERRCNT_LO 10
`define QTD_TOKEN_HI 9
`define QTD_TOKEN_LO 8

// Status byte bits.
`define QTD_ST_ACTIVE 7
`define QTD_ST_HALTED 6
`define QTD_ST_BUFERR 5
`define QTD_ST_BABBLE 4
`define QTD_ST_XACTERR 3
`define QTD_ST_MISSED 2
`define QTD_ST_SPLIT 1
`define QTD_ST_PING 0

// Token codes.
`define QTD_TOKEN_OUT 2'h0
`define QTD_TOKEN_IN 2'h1
`define QTD_TOKEN_SETUP 2'h2
`define QTD_TOKEN_RSVD 2'h3

// Last valid buffer page index.
`define QTD_LAST_PAGE 3'h4

`endif

// file: qtd_desc_mem.v
// Eight-word store holding the descriptor line being worked on.
`default_nettype none

module qtd_desc_mem (
	input wire clk_sys_in,
	input wire wr_en_in,
	input wire [2:0] wr_addr_in,
	input wire [31:0] wr_data_in,
	input wire [2:0] rd_addr_in,
	output reg [31:0] rd_data_out
);

	reg [31:0] mem_r [0:7];

	// Write port and registered read port; no reset on the array itself.
	always @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_r[rd_addr_in];
	end

endmodule

`default_nettype wire

// file: qtd_engine.v
// Queue transfer descriptor engine: fetch, execute and write back.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`default_nettype none
`include "qtd_consts.vh"

module qtd_engine (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	output reg mem_req_out,
	output reg mem_we_out,
	output reg [31:0] mem_addr_out,
	output reg [31:0] mem_wdata_out,
	input wire mem_ack_in,
	input wire [31:0] mem_rdata_in,
	output reg xact_start_out,
	output reg [1:0] xact_token_out,
	output reg xact_toggle_out,
	output reg xact_ping_out,
	output reg xact_split_out,
	output reg [31:0] xact_addr_out,
	output reg [14:0] xact_len_out,
	input wire xact_done_in,
	input wire [14:0] xact_bytes_in,
	input wire xact_short_in,
	input wire xact_err_in,
	input wire xact_serious_in,
	input wire xact_babble_in,
	input wire xact_buferr_in,
	input wire xact_ping_next_in,
	input wire xact_split_next_in,
	input wire thresh_tick_in,
	output reg notify_irq_out,
	output reg busy_out
);

	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_FETCH = 4'h1;
	localparam [3:0] ST_LOAD = 4'h2;
	localparam [3:0] ST_LOADW = 4'h3;
	localparam [3:0] ST_PAGE = 4'h4;
	localparam [3:0] ST_PAGEW = 4'h5;
	localparam [3:0] ST_EXEC = 4'h6;
	localparam [3:0] ST_WAIT = 4'h7;
	localparam [3:0] ST_WB2 = 4'h8;
	localparam [3:0] ST_WB3 = 4'h9;
	localparam [3:0] ST_NEXT = 4'hA;
	localparam [3:0] ST_HALT = 4'hB;

	reg [3:0] state_r;
	reg [3:0] idx_r;
	reg [31:0] head_r;
	reg [31:0] cur_r;
	reg [31:0] link_r;
	reg [31:0] alt_r;
	reg [31:0] word2_r;
	reg [19:0] page0_r;
	reg [11:0] offset_r;
	reg [19:0] page_base_r;
	reg short_r;
	reg notify_pend_r;
	reg stopped_r;
	reg mem_wr_r;
	reg [2:0] mem_rd_addr_r;
	wire [31:0] mem_q;
	reg [31:0] fetch_data_r;

	// Word two with the engine's results folded in after a transaction.
	reg [31:0] word2_nxt;
	reg [11:0] offset_nxt;
	reg [15:0] off_sum;
	reg [14:0] total;
	reg [1:0] errcnt;
	reg [7:0] status_byte;

	// A link is usable only when its terminate bit is clear.
	function link_ok;
		input [31:0] link;
		begin
			link_ok = ~link[`QTD_LINK_TERM];
		end
	endfunction

	// Byte address of a descriptor word: line base plus four times the word index.
	function [31:0] word_addr;
		input [31:0] base;
		input [2:0] word;
		begin
			word_addr = (base & `QTD_LINE_MASK) | {27'h0, word, 2'h0};
		end
	endfunction

	qtd_desc_mem u_mem (
		.clk_sys_in(clk_sys_in),
		.wr_en_in(mem_wr_r),
		.wr_addr_in(idx_r[2:0]),
		.wr_data_in(fetch_data_r),
		.rd_addr_in(mem_rd_addr_r),
		.rd_data_out(mem_q)
	);

	// Fold one transaction result into word two and the offset.
	always @* begin
		status_byte = word2_r[7:0];
		total = word2_r[`QTD_TOTAL_HI:`QTD_TOTAL_LO];
		errcnt = word2_r[`QTD_ERRCNT_HI:`QTD_ERRCNT_LO];
		word2_nxt = word2_r;
		off_sum = {4'h0, offset_r} + {1'b0, xact_bytes_in};
		offset_nxt = offset_r;
		if (xact_err_in) begin
			status_byte[`QTD_ST_XACTERR] = 1'b1;
			if (errcnt != 2'h0) begin
				errcnt = errcnt - 2'h1;
			end
			if (errcnt == 2'h0) begin
				status_byte[`QTD_ST_HALTED] = 1'b1;
				status_byte[`QTD_ST_ACTIVE] = 1'b0;
			end
		end else begin
			// A clean transfer flips the toggle and moves the byte pointers.
			word2_nxt[`QTD_TOGGLE_BIT] = ~word2_r[`QTD_TOGGLE_BIT];
			offset_nxt = off_sum[11:0];
			word2_nxt[`QTD_PAGE_HI:`QTD_PAGE_LO] =
				word2_r[`QTD_PAGE_HI:`QTD_PAGE_LO] + off_sum[14:12];
			if (xact_bytes_in >= total) begin
				total = 15'h0;
			end else begin
				total = total - xact_bytes_in;
			end
			status_byte[`QTD_ST_PING] = xact_ping_next_in;
			status_byte[`QTD_ST_SPLIT] = xact_split_next_in;
		end
		if (xact_serious_in) begin
			status_byte[`QTD_ST_HALTED] = 1'b1;
			status_byte[`QTD_ST_ACTIVE] = 1'b0;
		end
		if (xact_babble_in) begin
			status_byte[`QTD_ST_BABBLE] = 1'b1;
			status_byte[`QTD_ST_HALTED] = 1'b1;
			status_byte[`QTD_ST_ACTIVE] = 1'b0;
		end
		if (xact_buferr_in) begin
			status_byte[`QTD_ST_BUFERR] = 1'b1;
		end
		// Finished when all bytes moved or the endpoint ended short.
		if (!xact_err_in && (total == 15'h0 || xact_short_in)) begin
			status_byte[`QTD_ST_ACTIVE] = 1'b0;
		end
		word2_nxt[`QTD_TOTAL_HI:`QTD_TOTAL_LO] = total;
		word2_nxt[`QTD_ERRCNT_HI:`QTD_ERRCNT_LO] = errcnt;
		word2_nxt[7:0] = status_byte;
	end

	// Main sequencer: fetch the line, run transactions, write back, link on.
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
			idx_r <= 4'h0;
			head_r <= 32'h0;
			cur_r <= 32'h0;
			link_r <= 32'h1;
			alt_r <= 32'h1;
			word2_r <= 32'h0;
			page0_r <= 20'h0;
			offset_r <= 12'h0;
			page_base_r <= 20'h0;
			short_r <= 1'b0;
			notify_pend_r <= 1'b0;
			stopped_r <= 1'b0;
			fetch_data_r <= 32'h0;
			mem_wr_r <= 1'b0;
			mem_rd_addr_r <= 3'h0;
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_addr_out <= 32'h0;
			mem_wdata_out <= 32'h0;
			xact_start_out <= 1'b0;
			xact_token_out <= `QTD_TOKEN_OUT;
			xact_toggle_out <= 1'b0;
			xact_ping_out <= 1'b0;
			xact_split_out <= 1'b0;
			xact_addr_out <= 32'h0;
			xact_len_out <= 15'h0;
			notify_irq_out <= 1'b0;
			busy_out <= 1'b0;
			reg_rdata_out <= 32'h0;
		end else begin
			mem_wr_r <= 1'b0;
			xact_start_out <= 1'b0;
			notify_irq_out <= 1'b0;
			// Pending completion notice goes out on the next threshold tick.
			if (notify_pend_r && thresh_tick_in) begin
				notify_irq_out <= 1'b1;
				notify_pend_r <= 1'b0;
			end
			// Register writes; the head pointer may be set any time.
			if (reg_wr_in && reg_addr_in == `QTD_REG_HEAD) begin
				head_r <= reg_wdata_in & `QTD_LINE_MASK;
			end
			// Register reads answer in the next cycle only.
			reg_rdata_out <= 32'h0;
			if (reg_rd_in) begin
				case (reg_addr_in)
				`QTD_REG_CTRL: reg_rdata_out <= 32'h0;
				`QTD_REG_HEAD: reg_rdata_out <= head_r;
				`QTD_REG_STAT: reg_rdata_out <= {26'h0, stopped_r,
					busy_out, state_r};
				`QTD_REG_WORD2: reg_rdata_out <= word2_r;
				`QTD_REG_CUR: reg_rdata_out <= cur_r;
				default: reg_rdata_out <= 32'h0;
				endcase
			end
			case (state_r)
			ST_IDLE, ST_HALT: begin
				if (reg_wr_in && reg_addr_in == `QTD_REG_CTRL &&
						reg_wdata_in[`QTD_CTRL_START]) begin
					// The queue head supplies the first element.
					cur_r <= head_r;
					idx_r <= 4'h0;
					stopped_r <= 1'b0;
					busy_out <= 1'b1;
					mem_req_out <= 1'b1;
					mem_we_out <= 1'b0;
					mem_addr_out <= word_addr(head_r, 3'h0);
					state_r <= ST_FETCH;
				end
			end
			ST_FETCH: begin
				// Each returned word lands in the line store.
				if (mem_ack_in) begin
					mem_wr_r <= 1'b1;
					fetch_data_r <= mem_rdata_in; // Data stands only with ack.
					if (idx_r == `QTD_WORDS - 4'h1) begin
						mem_req_out <= 1'b0;
						state_r <= ST_LOAD;
					end else begin
						mem_addr_out <= word_addr(cur_r, idx_r[2:0] + 3'h1);
					end
				end
				if (mem_wr_r) begin
					idx_r <= idx_r + 4'h1;
				end
			end
			ST_LOAD: begin
				// Finish the last store write, then read words zero to three.
				if (mem_wr_r || idx_r == `QTD_WORDS) begin
					idx_r <= 4'h0;
					mem_rd_addr_r <= 3'h0;
				end else begin
					mem_rd_addr_r <= idx_r[2:0];
					state_r <= ST_LOADW;
				end
			end
			ST_LOADW: begin
				if (idx_r[2:0] != mem_rd_addr_r) begin
					idx_r <= {1'b0, mem_rd_addr_r};
				end else begin
					case (idx_r[1:0])
					2'h0: link_r <= mem_q;
					2'h1: alt_r <= mem_q;
					2'h2: word2_r <= mem_q;
					default: begin
						page0_r <= mem_q[31:12];
						offset_r <= mem_q[11:0];
					end
					endcase
					if (idx_r == 4'h3) begin
						state_r <= ST_PAGE;
					end else begin
						// Move the read address first; the index follows
						// a cycle later, once the store has caught up.
						mem_rd_addr_r <= idx_r[2:0] + 3'h1;
					end
				end
			end
			ST_PAGE: begin
				// Only run when software has marked the element active.
				if (!word2_r[`QTD_ST_ACTIVE]) begin
					state_r <= ST_NEXT;
				end else if (word2_r[`QTD_TOKEN_HI:`QTD_TOKEN_LO] ==
						`QTD_TOKEN_RSVD ||
						word2_r[`QTD_PAGE_HI:`QTD_PAGE_LO] >
						`QTD_LAST_PAGE) begin
					// Reserved token or page beyond four halts the queue.
					word2_r[`QTD_ST_HALTED] <= 1'b1;
					word2_r[`QTD_ST_ACTIVE] <= 1'b0;
					state_r <= ST_WB2;
				end else begin
					mem_rd_addr_r <= `QTD_WORD_PAGE0 +
						word2_r[`QTD_PAGE_HI:`QTD_PAGE_LO];
					idx_r <= 4'h0;
					state_r <= ST_PAGEW;
				end
			end
			ST_PAGEW: begin
				// One cycle for the store to present the page pointer.
				if (idx_r == 4'h0) begin
					idx_r <= 4'h1;
				end else begin
					page_base_r <= mem_q[31:12];
					state_r <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				xact_start_out <= 1'b1;
				xact_token_out <= word2_r[`QTD_TOKEN_HI:`QTD_TOKEN_LO];
				xact_toggle_out <= word2_r[`QTD_TOGGLE_BIT];
				xact_ping_out <= word2_r[`QTD_ST_PING];
				xact_split_out <= word2_r[`QTD_ST_SPLIT];
				xact_addr_out <= {page_base_r, offset_r};
				xact_len_out <= word2_r[`QTD_TOTAL_HI:`QTD_TOTAL_LO];
				state_r <= ST_WAIT;
			end
			ST_WAIT: begin
				if (xact_done_in) begin
					word2_r <= word2_nxt;
					offset_r <= offset_nxt;
					short_r <= xact_short_in && !xact_err_in;
					state_r <= ST_WB2;
				end
			end
			ST_WB2: begin
				// Status word first, then the offset word.
				mem_req_out <= 1'b1;
				mem_we_out <= 1'b1;
				mem_addr_out <= word_addr(cur_r, `QTD_WORD_TOGGLE);
				mem_wdata_out <= word2_r;
				if (mem_req_out && mem_ack_in) begin
					mem_addr_out <= word_addr(cur_r, `QTD_WORD_PAGE0);
					mem_wdata_out <= {page0_r, offset_r};
					state_r <= ST_WB3;
				end
			end
			ST_WB3: begin
				if (mem_ack_in) begin
					mem_req_out <= 1'b0;
					mem_we_out <= 1'b0;
					if (word2_r[`QTD_ST_HALTED]) begin
						// Halted element: leave the queue parked.
						stopped_r <= 1'b1;
						busy_out <= 1'b0;
						state_r <= ST_HALT;
					end else if (word2_r[`QTD_ST_ACTIVE]) begin
						state_r <= ST_PAGE;
					end else begin
						if (word2_r[`QTD_NOTIFY_BIT]) begin
							notify_pend_r <= 1'b1;
						end
						state_r <= ST_NEXT;
					end
				end
			end
			ST_NEXT: begin
				// Short packet takes the alternate link when it is valid.
				idx_r <= 4'h0;
				short_r <= 1'b0;
				if (short_r && link_ok(alt_r)) begin
					cur_r <= alt_r & `QTD_LINE_MASK;
					mem_addr_out <= word_addr(alt_r, 3'h0);
					mem_req_out <= 1'b1;
					state_r <= ST_FETCH;
				end else if (link_ok(link_r)) begin
					cur_r <= link_r & `QTD_LINE_MASK;
					mem_addr_out <= word_addr(link_r, 3'h0);
					mem_req_out <= 1'b1;
					state_r <= ST_FETCH;
				end else begin
					busy_out <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
			// Abort drops any memory request and parks the engine.
			if (reg_wr_in && reg_addr_in == `QTD_REG_CTRL &&
					reg_wdata_in[`QTD_CTRL_ABORT]) begin
				mem_req_out <= 1'b0;
				mem_we_out <= 1'b0;
				busy_out <= 1'b0;
				state_r <= ST_IDLE;
			end
		end
	end

endmodule

`default_nettype wire

// file: qtd_engine_monitor.sv
// Port checker for the descriptor engine, bound into the engine.
`default_nettype none
module qtd_engine_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic mem_req_out,
	input wire logic mem_we_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic mem_ack_in,
	input wire logic xact_start_out,
	input wire logic [1:0] xact_token_out,
	input wire logic [31:0] xact_addr_out,
	input wire logic [14:0] xact_len_out,
	input wire logic xact_done_in,
	input wire logic thresh_tick_in,
	input wire logic notify_irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic in_xact_r;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Marks the span between a start pulse and its done pulse.
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			in_xact_r <= 1'b0;
		else if (xact_start_out)
			in_xact_r <= 1'b1;
		else if (xact_done_in)
			in_xact_r <= 1'b0;
	end
	read_idle_zero_a: assert property (!$past(reg_rd_in) |->
		reg_rdata_out == 32'h0) else $error("read data outside slot");
	start_one_cycle_a: assert property (xact_start_out |=>
		!xact_start_out) else $error("start pulse too long");
	token_legal_a: assert property (xact_start_out |->
		xact_token_out != 2'h3) else $error("reserved token issued");
	xact_fields_hold_a: assert property (!xact_start_out |->
		$stable({xact_token_out, xact_addr_out, xact_len_out}))
		else $error("transaction fields moved");
	req_hold_a: assert property (mem_req_out && !mem_ack_in |=>
		mem_req_out && $stable(mem_addr_out)) else $error("request dropped");
	fetch_step_a: assert property (mem_req_out && mem_ack_in &&
		!mem_we_out && mem_addr_out[4:2] != 3'h7 |=> mem_req_out &&
		mem_addr_out == $past(mem_addr_out) + 32'h4)
		else $error("fetch word order wrong");
	fetch_end_a: assert property (mem_req_out && mem_ack_in &&
		!mem_we_out && mem_addr_out[4:2] == 3'h7 |=> !mem_req_out)
		else $error("fetch ran past line");
	writeback_word_a: assert property (in_xact_r && xact_done_in |=>
		##1 mem_req_out && mem_we_out && mem_addr_out[4:0] == 5'h08)
		else $error("write-back did not follow done");
	irq_on_tick_a: assert property (notify_irq_out |->
		$past(thresh_tick_in)) else $error("notify without threshold");
endmodule
bind qtd_engine qtd_engine_monitor qtd_engine_monitor_inst (.clk_sys_in,
	.rst_n_in, .reg_rd_in, .reg_rdata_out, .mem_req_out, .mem_we_out,
	.mem_addr_out, .mem_ack_in, .xact_start_out, .xact_token_out,
	.xact_addr_out, .xact_len_out, .xact_done_in, .thresh_tick_in,
	.notify_irq_out);
`default_nettype wire

// file: qtd_mem_model.sv
// Behavioural system memory that answers the engine's word requests.
`default_nettype none
module qtd_mem_model (
	input wire logic clk_sys_in,
	input wire logic mem_req_in,
	input wire logic mem_we_in,
	input wire logic [31:0] mem_addr_in,
	input wire logic [31:0] mem_wdata_in,
	input wire logic [1:0] lat_in,
	output logic mem_ack_out,
	output logic [31:0] mem_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:1023];
	logic [1:0] wait_r = 2'h0;
	initial mem_ack_out = 1'b0;
	initial mem_rdata_out = 32'h0;
	// Word n of a line sits at base + 4n; idle read data flips each cycle.
	always @(posedge clk_sys_in) begin
		mem_ack_out <= 1'b0;
		mem_rdata_out <= ~mem_rdata_out;
		if (mem_req_in && !mem_ack_out && wait_r == lat_in) begin
			mem_ack_out <= 1'b1;
			wait_r <= 2'h0;
			if (mem_we_in)
				mem[mem_addr_in[11:2]] <= mem_wdata_in;
			else
				mem_rdata_out <= mem[mem_addr_in[11:2]];
		end else if (mem_req_in && !mem_ack_out) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the descriptor engine.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0, xact_done_in = 1'b0, xact_short_in = 1'b0;
	logic xact_err_in = 1'b0, xact_serious_in = 1'b0, xact_babble_in = 1'b0;
	logic xact_buferr_in = 1'b0, xact_ping_next_in = 1'b0;
	logic xact_split_next_in = 1'b0, thresh_tick_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic [14:0] xact_bytes_in = 15'h0;
	logic [1:0] lat = 2'h0;
	wire logic [31:0] reg_rdata_out, mem_addr_out, mem_wdata_out;
	wire logic [31:0] mem_rdata_in, xact_addr_out;
	wire logic mem_req_out, mem_we_out, mem_ack_in, xact_start_out;
	wire logic xact_toggle_out, xact_ping_out, xact_split_out;
	wire logic notify_irq_out, busy_out;
	wire logic [1:0] xact_token_out;
	wire logic [14:0] xact_len_out;
	int err_total = 0;
	int n_checks = 0;
	qtd_engine qtd_engine_inst (.clk_sys_in, .rst_n_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_req_out,
		.mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in,
		.mem_rdata_in, .xact_start_out, .xact_token_out, .xact_toggle_out,
		.xact_ping_out, .xact_split_out, .xact_addr_out, .xact_len_out,
		.xact_done_in, .xact_bytes_in, .xact_short_in, .xact_err_in,
		.xact_serious_in, .xact_babble_in, .xact_buferr_in,
		.xact_ping_next_in, .xact_split_next_in, .thresh_tick_in,
		.notify_irq_out, .busy_out);
	qtd_mem_model qtd_mem_model_inst (.clk_sys_in, .mem_req_in(mem_req_out),
		.mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out),
		.mem_wdata_in(mem_wdata_out), .lat_in(lat),
		.mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
	// The clock toggles every half period of 2.5 ns, a 5 ns period.
	always #2.5 clk_sys_in = ~clk_sys_in;
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function logic [31:0] m(input int w);
		return qtd_mem_model_inst.mem[w];
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	// Waits a bounded time for start, idle, notify or a line fetch.
	task wait_for(input int sel);
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_sys_in);
			thresh_tick_in <= 1'b0;
			#1;
			if (sel == 0 && xact_start_out === 1'b1) return;
			if (sel == 1 && busy_out === 1'b0) return;
			if (sel == 2 && notify_irq_out === 1'b1) return;
			if (sel == 3 && mem_req_out === 1'b1 && mem_we_out === 1'b0 &&
				mem_addr_out[4:0] === 5'h00) return;
		end
		err_total++;
		$display("[ERR] %0t wait ran out", $time);
		give_verdict;
	endtask
	task done(input logic [14:0] n, input logic s, input logic e);
		@(posedge clk_sys_in);
		xact_done_in <= 1'b1;
		xact_bytes_in <= n;
		xact_short_in <= s;
		xact_err_in <= e;
		@(posedge clk_sys_in);
		xact_done_in <= 1'b0;
	endtask
	// Software builds a descriptor line, page one at 0x2000.
	task put(input int w, input logic [31:0] n, a, d2, d3);
		qtd_mem_model_inst.mem[w] = n;
		qtd_mem_model_inst.mem[w + 1] = a;
		qtd_mem_model_inst.mem[w + 2] = d2;
		qtd_mem_model_inst.mem[w + 3] = d3;
		qtd_mem_model_inst.mem[w + 4] = 32'h00002000;
	endtask
	task t_regs;
		logic [31:0] d;
		wr(8'h04, 32'h0000013F);
		rd(8'h04, d);
		chk(d, 32'h00000120);
		rd(8'h14, d);
		chk(d, 32'h0);
		$display("t_regs finished");
	endtask
	task t_pages;
		put(64, 32'h1, 32'h1, {1'b1, 15'd8, 1'b1, 3'd0, 2'd3, 2'd1, 8'h80},
			32'h00001FFC);
		wr(8'h04, 32'h100);
		wr(8'h00, 32'h1);
		wait_for(0);
		chk(32'(xact_token_out), 32'h1);
		chk(32'(xact_toggle_out), 32'h1);
		chk(xact_addr_out, 32'h00001FFC);
		chk(32'(xact_len_out), 32'h8);
		done(15'd4, 1'b0, 1'b0);
		wait_for(0);
		chk(xact_addr_out, 32'h00002000);
		chk(32'(xact_len_out), 32'h4);
		chk(32'(xact_toggle_out), 32'h0);
		done(15'd4, 1'b0, 1'b0);
		wait_for(1);
		chk(m(66), {1'b1, 15'd0, 1'b1, 3'd1, 2'd3, 2'd1, 8'h00});
		chk(m(67), 32'h00001004);
		@(posedge clk_sys_in);
		thresh_tick_in <= 1'b1;
		wait_for(2);
		$display("t_pages finished");
	endtask
	task t_short;
		lat <= 2'h2;
		put(128, 32'h280, 32'h300, {1'b0, 15'd16, 1'b0, 3'd0, 2'd3, 2'd0,
			8'h83}, 32'h00001000);
		put(192, 32'h1, 32'h1, {1'b0, 15'd4, 1'b0, 3'd0, 2'd3, 2'd0, 8'h00},
			32'h00001000);
		wr(8'h04, 32'h200);
		wr(8'h00, 32'h1);
		wait_for(0);
		chk(32'(xact_token_out), 32'h0);
		chk(32'(xact_ping_out), 32'h1);
		chk(32'(xact_split_out), 32'h1);
		done(15'd4, 1'b1, 1'b0);
		wait_for(3);
		chk(mem_addr_out, 32'h00000300);
		wait_for(1);
		chk(m(130), {1'b1, 15'd12, 1'b0, 3'd0, 2'd3, 2'd0, 8'h00});
		lat <= 2'h0;
		$display("t_short finished");
	endtask
	task t_error;
		logic [31:0] d;
		put(256, 32'h1, 32'h1, {1'b0, 15'd8, 1'b0, 3'd0, 2'd2, 2'd2, 8'h80},
			32'h00001000);
		wr(8'h04, 32'h400);
		wr(8'h00, 32'h1);
		wait_for(0);
		chk(32'(xact_token_out), 32'h2);
		done(15'd0, 1'b0, 1'b1);
		wait_for(0);
		done(15'd0, 1'b0, 1'b1);
		wait_for(1);
		chk(m(258), {1'b0, 15'd8, 1'b0, 3'd0, 2'd0, 2'd2, 8'h48});
		rd(8'h08, d);
		chk(32'(d[5:4]), 32'h2);
		$display("t_error finished");
	endtask
	// Buffer error, babble, serious error, reserved token and bad page.
	task t_faults;
		put(320, 32'h1, 32'h1, {1'b0, 15'd8, 1'b0, 3'd0, 2'd3, 2'd1, 8'h80},
			32'h00001000);
		wr(8'h04, 32'h500);
		wr(8'h00, 32'h1);
		wait_for(0);
		xact_buferr_in <= 1'b1;
		done(15'd4, 1'b0, 1'b0);
		xact_buferr_in <= 1'b0;
		wait_for(0);
		chk(xact_addr_out, 32'h00001004);
		chk(32'(xact_len_out), 32'h4);
		xact_babble_in <= 1'b1;
		done(15'd2, 1'b0, 1'b0);
		xact_babble_in <= 1'b0;
		wait_for(1);
		chk(m(322), {1'b0, 15'd2, 1'b0, 3'd0, 2'd3, 2'd1, 8'h70});
		chk(m(323), 32'h00001006);
		put(320, 32'h1, 32'h1, {1'b1, 15'd8, 1'b0, 3'd0, 2'd3, 2'd1, 8'h80},
			32'h00001000);
		wr(8'h00, 32'h1);
		wait_for(0);
		chk(32'(xact_toggle_out), 32'h1);
		xact_serious_in <= 1'b1;
		done(15'd0, 1'b0, 1'b0);
		xact_serious_in <= 1'b0;
		wait_for(1);
		chk(m(322), {1'b0, 15'd8, 1'b0, 3'd0, 2'd3, 2'd1, 8'h40});
		put(320, 32'h1, 32'h1, {1'b0, 15'd8, 1'b0, 3'd0, 2'd3, 2'd3, 8'h80},
			32'h00001000);
		wr(8'h00, 32'h1);
		wait_for(1);
		chk(m(322), {1'b0, 15'd8, 1'b0, 3'd0, 2'd3, 2'd3, 8'h40});
		put(320, 32'h1, 32'h1, {1'b0, 15'd8, 1'b0, 3'd5, 2'd3, 2'd1, 8'h80},
			32'h00001000);
		wr(8'h00, 32'h1);
		wait_for(1);
		chk(m(322), {1'b0, 15'd8, 1'b0, 3'd5, 2'd3, 2'd1, 8'h40});
		$display("t_faults finished");
	endtask
	// Abort, then a reset in mid-transfer, both park the engine at idle.
	task t_reset;
		logic [31:0] d;
		put(320, 32'h1, 32'h1, {1'b0, 15'd8, 1'b0, 3'd0, 2'd3, 2'd1, 8'h80},
			32'h00001000);
		wr(8'h00, 32'h1);
		wait_for(0);
		wr(8'h00, 32'h2);
		rd(8'h08, d);
		chk(d, 32'h0);
		wr(8'h00, 32'h1);
		wait_for(0);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1 chk({28'h0, busy_out, mem_req_out, xact_start_out, notify_irq_out},
			32'h0);
		rd(8'h04, d);
		chk(d, 32'h0);
		$display("t_reset finished");
	endtask
	// Reset for five cycles, then run every scenario.
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_regs;
		t_pages;
		t_short;
		t_error;
		t_faults;
		t_reset;
		give_verdict;
	end
endmodule
`default_nettype wire
